/* File: logic/mcf_pkg.sv */
/*
  Shared constants and types of the timer block: register offsets,
  field positions, reset values, pin indices, modes and carrier structs.
  Assumes a 16-bit register port and a single system clock.
*/
package mcf_pkg;
  // register offsets (word index on the register port)
  localparam logic [3:0] A_CFG  = 4'h0;  // bus_interface_config_register
  localparam logic [3:0] A_VEC  = 4'h1;  // interrupt vector number
  localparam logic [3:0] A_MSC  = 4'h2;  // modulus_status_control_register
  localparam logic [3:0] A_MCNT = 4'h3;  // modulus_count_value
  localparam logic [3:0] A_MLAT = 4'h4;  // modulus_reload_latch
  localparam logic [3:0] A_FCNT = 4'h5;  // free-running count
  localparam logic [3:0] A_DDAT = 4'h6;  // dual action compare/capture
  localparam logic [3:0] A_DCTL = 4'h7;  // dual action control/status
  localparam logic [3:0] A_PCNT = 4'h8;  // pulse width counter
  localparam logic [3:0] A_FSC  = 4'h9;  // free-running status

  // field positions
  localparam int CFG_FRZ    = 15;  // halt_response_bit
  localparam int CFG_LVL_LO = 8;   // interrupt level, 3 bits
  localparam int CFG_ARB_LO = 0;   // arbitration number, 4 bits
  localparam int MSC_COF    = 15;  // counter_overflow_flag
  localparam int MSC_IEN    = 14;  // overflow interrupt enable
  localparam int MSC_CLK    = 13;  // clock_port_level
  localparam int MSC_LD     = 12;  // load_port_level
  localparam int MSC_SEL    = 0;   // 1: external clock pin
  localparam int DCTL_LVL   = 15;  // dual action level flag
  localparam int DCTL_OFF   = 14;  // output flip-flop
  localparam int FSC_LVL    = 15;  // free-running level flag

  // reset values and counts
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [7:0]  VEC_RST  = 8'h0f;
  localparam logic [15:0] MLAT_RST = 16'h0000;
  localparam logic [15:0] REG_RST  = 16'h0000;
  localparam logic [1:0]  PRE_LAST = 2'h1;   // first_prescaled_clock = clock / 2
  localparam logic [7:0]  PWM_PRE_RELOAD = 8'h00;

  // synchronised pin indices
  localparam int NPIN   = 4;
  localparam int P_MCK  = 0;  // modulus external clock pin
  localparam int P_MLD  = 1;  // modulus load pin
  localparam int P_FCK  = 2;  // free-running external clock pin
  localparam int P_DPIN = 3;  // dual action pin

  typedef enum logic [2:0] {
    MD_LEVEL_ONLY = 3'h0,  // level_only_mode
    MD_CAPTURE    = 3'h1,  // single_capture_mode
    MD_PERIOD     = 3'h2,  // period_measure_mode
    MD_PULSE_IN   = 3'h3,  // input_pulse_measure_mode
    MD_OC_B       = 3'h4,  // output_compare_b_mode
    MD_OC_AB      = 3'h5,  // output_compare_ab_mode
    MD_PULSE_OUT  = 3'h6   // output_pulse_mode
  } mcf_mode_t;

  typedef struct packed {
    logic        vld;
    logic        wr;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } mcf_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mcf_rsp_t;

  typedef struct packed {
    logic [15:0] one;
    logic [15:0] two;
    logic [15:0] four;
  } mcf_tbb_t;
endpackage

/* File: logic/mcf_cnt.sv */
/*
  Reloadable up counter with overflow pulse, shared by the modulus,
  free-running and pulse width counters and the pulse width prescaler.
  Assumes the caller gates inc_i with the freeze state.
*/
module mcf_cnt #(
  parameter int W = 16
) (
  input  wire logic         clock_i,
  input  wire logic         rst_b_i,
  input  wire logic         inc_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  input  wire logic [W-1:0] reload_i,
  output logic      [W-1:0] cnt_o,
  output logic              ovf_o
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // a direct load beats an overflow in the same cycle
  assign ovf_o = inc_i & (&cnt_q) & ~load_i;
  assign cnt_o = cnt_q;

  always_comb
  begin
    cnt_d = cnt_q;
    if (load_i)
      cnt_d = load_val_i;
    else if (ovf_o)
      cnt_d = reload_i;
    else if (inc_i)
      cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

/* File: logic/mcf_timer.sv */
/*
  Timer module top: bus interface with freeze gating and interrupt
  acknowledge, clock prescaler, modulus counter, free-running counter,
  one dual action channel, one pulse width counter, time base buses.
  Assumes freeze_i and the interrupt acknowledge come from logic on
  clock_i; the four pins are asynchronous and are synchronised here.
*/
// Functional notes
// R1 - sixteen-bit modulus latch, always readable and writable, reloads the counter
// R2 - latch write changes only the latch; counter takes it at next load
// R3 - counter write loads counter and latch together at once
// R4 - reset clears the modulus latch to zero
// R5 - sixteen-bit counter with incrementer; reads return current count
// R6 - overflow reloads from latch and sets the overflow flag
// R7 - latch all ones flags overflow on every counter clock pulse
// R8 - freeze reaches all submodules gated by one halt response bit
// R9 - freeze with halt bit set freezes submodules; registers stay accessible
// R10 - frozen: prescaler, free-running, modulus and pulse width counters stop
// R11 - frozen: modulus clock and load level flags still follow pins
// R12 - frozen: free-running level flag still follows its clock pin
// R13 - frozen: dual action capture and compare are disabled
// R14 - dual action level flag: pin in input modes, flip-flop in output
// R15 - processor stop halts only the processor; timer keeps running
// R16 - forward interrupt requests; supply level, arbitration, vector on acknowledge
// R17 - pulse width counter: own 16-bit counter, 8-bit prescaler, first prescaled clock
// R18 - bus two global; bus one and bus four are local segments; the code drives bus four with the free-running count, same as bus two
// R19 - unfrozen modulus counter increments per selected clock, reloads past maximum
module mcf_timer (
  input  wire logic                  clock_i,
  input  wire logic                  rst_b_i,
  input  wire mcf_pkg::mcf_req_t     bus_i,
  output mcf_pkg::mcf_rsp_t          bus_o,
  input  wire logic                  freeze_i,
  input  wire logic                  iack_i,
  input  wire logic [2:0]            iack_level_i,
  output logic      [2:0]            irq_level_o,
  output logic                       iack_ack_o,
  output logic      [7:0]            iack_vector_o,
  output logic      [3:0]            iack_arb_o,
  input  wire logic [mcf_pkg::NPIN-1:0] pins_i,
  output logic                       dual_action_submodule_pin_o,
  output mcf_pkg::mcf_tbb_t          tbb_o
);
  logic [mcf_pkg::NPIN-1:0] s1_q, s2_q, s3_q;
  logic [15:0] cfg_q, mlat_q, ddat_q;
  logic [7:0]  vec_q;
  logic        cof_q, ien_q, sel_q, off_q, eq_q;
  logic [2:0]  mode_q;
  logic [1:0]  pre_q;
  logic        ack_q, iack_q;
  logic [15:0] rdata_q, rd_mux;
  logic [7:0]  ivec_q;
  logic [3:0]  iarb_q;
  logic [15:0] mcnt, fcnt, pcnt;
  logic [7:0]  ppre;
  logic        movf, pre_ovf;

  // wrap targets of the counters that software never loads
  wire [15:0] wrap16 = mcf_pkg::REG_RST;
  wire [7:0]  wrap8  = mcf_pkg::PWM_PRE_RELOAD;

  // pin synchronisers; s3 only feeds edge detection
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  wire [mcf_pkg::NPIN-1:0] rise = s2_q & ~s3_q;

  // one gated freeze for every submodule
  wire frozen = freeze_i & cfg_q[mcf_pkg::CFG_FRZ]; // R8 R9

  // register port decode
  wire wr      = bus_i.vld & bus_i.wr;
  wire wr_cfg  = wr & (bus_i.addr == mcf_pkg::A_CFG);
  wire wr_vec  = wr & (bus_i.addr == mcf_pkg::A_VEC);
  wire wr_msc  = wr & (bus_i.addr == mcf_pkg::A_MSC);
  wire wr_mcnt = wr & (bus_i.addr == mcf_pkg::A_MCNT);
  wire wr_mlat = wr & (bus_i.addr == mcf_pkg::A_MLAT);
  wire wr_ddat = wr & (bus_i.addr == mcf_pkg::A_DDAT);
  wire wr_dctl = wr & (bus_i.addr == mcf_pkg::A_DCTL);

  // prescaler; no stop input exists, so only freeze halts it
  wire first_prescaled_clock = ~frozen & (pre_q == mcf_pkg::PRE_LAST); // R10 R15
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pre_q <= '0;
    else if (!frozen)
      pre_q <= first_prescaled_clock ? '0 : pre_q + 1'b1; // R10
  end

  // modulus counter clock and load selection
  wire mclk  = sel_q ? rise[mcf_pkg::P_MCK] : first_prescaled_clock;
  wire minc  = ~frozen & mclk; // R10 R19
  wire mldp  = ~frozen & rise[mcf_pkg::P_MLD];
  wire mload = wr_mcnt | mldp; // R2 R3
  wire [15:0] mload_val = wr_mcnt ? bus_i.wdata : mlat_q;

  mcf_cnt #(.W(16)) u_mcnt (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .inc_i      (minc),
    .load_i     (mload),
    .load_val_i (mload_val),
    .reload_i   (mlat_q),
    .cnt_o      (mcnt),
    .ovf_o      (movf)
  ); // R5 R6 R7 R19

  // free-running counter wraps to zero, feeds the global bus
  mcf_cnt #(.W(16)) u_fcnt (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .inc_i      (first_prescaled_clock),
    .load_i     (1'b0),
    .load_val_i (wrap16),
    .reload_i   (wrap16),
    .cnt_o      (fcnt),
    .ovf_o      ()
  ); // R10

  // pulse width prescaler and counter, off every time base bus
  mcf_cnt #(.W(8)) u_ppre (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .inc_i      (first_prescaled_clock),
    .load_i     (1'b0),
    .load_val_i (wrap8),
    .reload_i   (wrap8),
    .cnt_o      (ppre),
    .ovf_o      (pre_ovf)
  ); // R17

  mcf_cnt #(.W(16)) u_pcnt (
    .clock_i    (clock_i),
    .rst_b_i    (rst_b_i),
    .inc_i      (pre_ovf),
    .load_i     (1'b0),
    .load_val_i (wrap16),
    .reload_i   (wrap16),
    .cnt_o      (pcnt),
    .ovf_o      ()
  ); // R17

  // time base buses: two is global, one is the local modulus segment, four carries the free-running count as two does
  assign tbb_o.two  = fcnt; // R18
  assign tbb_o.one  = mcnt; // R18
  assign tbb_o.four = fcnt; // R18

  // overflow flag: hardware set beats a software clear
  wire cof_d = movf | (cof_q & ~(wr_msc & ~bus_i.wdata[mcf_pkg::MSC_COF])); // R6

  // dual action channel on the local bus one segment
  wire is_out = (mode_q == mcf_pkg::MD_OC_B) | (mode_q == mcf_pkg::MD_OC_AB)
              | (mode_q == mcf_pkg::MD_PULSE_OUT);
  wire is_cap = ~is_out & (mode_q != mcf_pkg::MD_LEVEL_ONLY);
  wire cap    = ~frozen & is_cap & rise[mcf_pkg::P_DPIN]; // R13
  wire eq     = (tbb_o.one == ddat_q);
  wire cmp    = ~frozen & is_out & eq & ~eq_q; // R13
  wire dlvl   = is_out ? off_q : s2_q[mcf_pkg::P_DPIN]; // R14
  assign dual_action_submodule_pin_o = off_q;

  // register writes; latch and counter stay writable while frozen
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_q  <= mcf_pkg::CFG_RST;
      vec_q  <= mcf_pkg::VEC_RST;
      mlat_q <= mcf_pkg::MLAT_RST; // R4
      cof_q  <= 1'b0;
      ien_q  <= 1'b0;
      sel_q  <= 1'b0;
      ddat_q <= mcf_pkg::REG_RST;
      mode_q <= mcf_pkg::MD_LEVEL_ONLY;
      off_q  <= 1'b0;
      eq_q   <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= bus_i.wdata;
      if (wr_vec)
        vec_q <= bus_i.wdata[7:0];
      if (wr_mcnt | wr_mlat)
        mlat_q <= bus_i.wdata; // R1 R2 R3 R9
      cof_q <= cof_d;
      if (wr_msc)
      begin
        ien_q <= bus_i.wdata[mcf_pkg::MSC_IEN];
        sel_q <= bus_i.wdata[mcf_pkg::MSC_SEL];
      end
      if (cap)
        ddat_q <= tbb_o.one; // R13
      else if (wr_ddat)
        ddat_q <= bus_i.wdata;
      if (wr_dctl)
        mode_q <= bus_i.wdata[2:0];
      if (cmp)
        off_q <= ~off_q;
      eq_q <= eq;
    end
  end

  // read mux; level flags track the pins even while frozen
  always_comb
  begin
    rd_mux = '0;
    unique case (bus_i.addr)
      mcf_pkg::A_CFG:  rd_mux = cfg_q;
      mcf_pkg::A_VEC:  rd_mux = {8'h00, vec_q};
      mcf_pkg::A_MSC:
      begin
        rd_mux[mcf_pkg::MSC_COF] = cof_q;
        rd_mux[mcf_pkg::MSC_IEN] = ien_q;
        rd_mux[mcf_pkg::MSC_CLK] = s2_q[mcf_pkg::P_MCK]; // R11
        rd_mux[mcf_pkg::MSC_LD]  = s2_q[mcf_pkg::P_MLD]; // R11
        rd_mux[mcf_pkg::MSC_SEL] = sel_q;
      end
      mcf_pkg::A_MCNT: rd_mux = mcnt; // R5
      mcf_pkg::A_MLAT: rd_mux = mlat_q; // R1
      mcf_pkg::A_FCNT: rd_mux = fcnt;
      mcf_pkg::A_DDAT: rd_mux = ddat_q;
      mcf_pkg::A_DCTL:
      begin
        rd_mux[mcf_pkg::DCTL_LVL] = dlvl; // R14
        rd_mux[mcf_pkg::DCTL_OFF] = off_q;
        rd_mux[2:0] = mode_q;
      end
      mcf_pkg::A_PCNT: rd_mux = pcnt;
      mcf_pkg::A_FSC:  rd_mux[mcf_pkg::FSC_LVL] = s2_q[mcf_pkg::P_FCK]; // R12
      default:         rd_mux = '0;
    endcase
  end

  // interrupt request and acknowledge
  wire [2:0] lvl = cfg_q[mcf_pkg::CFG_LVL_LO +: 3];
  wire irq_req  = cof_q & ien_q;
  wire iack_hit = iack_i & irq_req & (iack_level_i == lvl) & (lvl != 3'h0);
  assign irq_level_o = irq_req ? lvl : 3'h0; // R16

  // answers are registered: one cycle after the request
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
      iack_q  <= 1'b0;
      ivec_q  <= '0;
      iarb_q  <= '0;
    end
    else
    begin
      ack_q   <= bus_i.vld;
      rdata_q <= (bus_i.vld & ~bus_i.wr) ? rd_mux : '0;
      iack_q  <= iack_hit; // R16
      ivec_q  <= iack_hit ? vec_q : '0;
      iarb_q  <= iack_hit ? cfg_q[mcf_pkg::CFG_ARB_LO +: 4] : '0;
    end
  end

  assign bus_o.ack     = ack_q;
  assign bus_o.rdata   = rdata_q;
  assign iack_ack_o    = iack_q;
  assign iack_vector_o = ivec_q;
  assign iack_arb_o    = iarb_q;

  // checks on the modulus counter, freeze, dual action level and acknowledge paths
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  a_latch_only: assert property (wr_mlat |=> mlat_q == $past(bus_i.wdata) && mcnt != $past(bus_i.wdata)
    || $past(mcnt) == $past(bus_i.wdata) || $past(movf | mload | minc)) else $error("latch write hit counter"); // R2
  a_count_write: assert property (wr_mcnt |=> mcnt == $past(bus_i.wdata) && mlat_q == $past(bus_i.wdata))
    else $error("counter write did not load both"); // R3
  a_ovf_reload: assert property (movf |=> mcnt == $past(mlat_q) && cof_q)
    else $error("overflow did not reload and flag"); // R6
  a_ones_every: assert property (mlat_q == 16'hffff && mcnt == 16'hffff && minc && !mload |-> movf)
    else $error("all ones latch missed overflow"); // R7
  a_freeze_gate: assert property (!cfg_q[mcf_pkg::CFG_FRZ] |-> !frozen && (!freeze_i || !frozen))
    else $error("freeze passed with halt bit clear"); // R8
  a_frozen_hold: assert property (frozen && !mload |=> $stable(mcnt) && $stable(fcnt) && $stable(pcnt))
    else $error("counter moved while frozen"); // R10
  a_pin_follow: assert property (rd_mux[mcf_pkg::MSC_LD] == $past(pins_i[mcf_pkg::P_MLD], 2)
    || bus_i.addr != mcf_pkg::A_MSC) else $error("load level lost its pin"); // R11
  a_cap_frozen: assert property (frozen && !wr_ddat |=> $stable(ddat_q) && $stable(off_q))
    else $error("capture or compare while frozen"); // R13
  a_out_level: assert property (is_out |-> dlvl == off_q)
    else $error("output mode level not flip-flop"); // R14
  a_iack_answer: assert property (iack_hit |=> iack_ack_o && iack_vector_o == $past(vec_q) ##1 !iack_ack_o
    || $past(iack_hit)) else $error("acknowledge answer wrong"); // R16

  c_overflow: cover property (movf ##1 cof_q);
  c_frozen_write: cover property (frozen && wr_mcnt);
  c_iack: cover property (irq_req ##[1:20] iack_ack_o);
endmodule

/* File: verif/mcf_cpu.sv */
/*
  Processor-side model on the intermodule bus: register requests,
  interrupt acknowledge cycles and the freeze line.
  Assumes its tasks are called from one bench process, on clock_i.
*/
module mcf_cpu (
  input  wire logic         clock_i,
  output mcf_pkg::mcf_req_t bus_o,
  output logic              freeze_o,
  output logic              iack_o,
  output logic [2:0]        iack_level_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial
  begin
    bus_o = '0;
    freeze_o = 1'b0;
    iack_o = 1'b0;
    iack_level_o = 3'h0;
  end

  // one request held for exactly one taking edge
  task automatic access(input logic wr, input logic [3:0] addr, input logic [15:0] d);
    @(posedge clock_i);
    bus_o <= '{vld: 1'b1, wr: wr, addr: addr, wdata: d};
    @(posedge clock_i);
    // released lines show the inverse, never a stale copy
    bus_o <= '{vld: 1'b0, wr: ~wr, addr: ~addr, wdata: ~d};
  endtask

  // acknowledge cycle for one level
  task automatic ack_cycle(input logic [2:0] lvl);
    @(posedge clock_i);
    iack_o <= 1'b1;
    iack_level_o <= lvl;
    @(posedge clock_i);
    iack_o <= 1'b0;
    iack_level_o <= ~lvl;
  endtask

  task automatic set_freeze(input logic f);
    @(posedge clock_i);
    freeze_o <= f;
  endtask
endmodule

/* File: verif/modulus_counter_freeze_control_bench.sv */
/*
  Self-checking bench of the timer top: latch and counter registers,
  freeze gating, pin level flags, overflow and interrupt acknowledge.
  Assumes mcf_cpu as the bus master and the register map of mcf_pkg.
*/
`define CHK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin miscompares++; \
  $display("[FAIL] %s expected %h seen %h", name, exp, got); end end

module modulus_counter_freeze_control_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clock_i = 1'b0;
  logic              rst_b_i = 1'b0;
  logic [3:0]        pins_i  = 4'h0;
  mcf_pkg::mcf_req_t bus_req;
  mcf_pkg::mcf_rsp_t bus_rsp;
  mcf_pkg::mcf_tbb_t tbb;
  logic              freeze;
  logic              iack;
  logic [2:0]        iack_level;
  logic [2:0]        irq_level;
  logic              iack_ack;
  logic [7:0]        iack_vector;
  logic [3:0]        iack_arb;
  int                miscompares = 0;
  int                checks_done = 0;
  logic [31:0]       rd_q[$];
  logic [11:0]       ia_q[$];
  logic [31:0]       e_rd;
  logic [11:0]       e_ia;
  logic [15:0]       lat_v;
  logic [3:0]        p_v;
  logic              dual_action_submodule_pin;
  logic [15:0]       fr_v;

  always #4 clock_i = ~clock_i;

  mcf_cpu i_mcf_cpu (.clock_i(clock_i), .bus_o(bus_req), .freeze_o(freeze), .iack_o(iack),
    .iack_level_o(iack_level));

  mcf_timer i_mcf_timer (.clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_req), .bus_o(bus_rsp),
    .freeze_i(freeze), .iack_i(iack), .iack_level_i(iack_level), .irq_level_o(irq_level),
    .iack_ack_o(iack_ack), .iack_vector_o(iack_vector), .iack_arb_o(iack_arb), .pins_i(pins_i),
    .dual_action_submodule_pin_o(dual_action_submodule_pin), .tbb_o(tbb));

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // every answer also notes rdata: writes must return zero
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    rd_q.push_back({16'h0000, 16'hffff});
    i_mcf_cpu.access(1'b1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    rd_q.push_back({e, m});
    i_mcf_cpu.access(1'b0, a, 16'h0000);
  endtask

  // pin change, then time for the two-flop synchroniser and edge logic
  task automatic pin_to(input logic [3:0] v);
    @(posedge clock_i);
    pins_i <= v;
    repeat (4) @(posedge clock_i);
  endtask

  // answer watcher: oldest note against each strobe
  always @(posedge clock_i)
  begin
    if (bus_rsp.ack === 1'b1)
    begin
      if (rd_q.size() == 0) `CHK("stray ack", 1'b0, 1'b1)
      else
      begin
        e_rd = rd_q.pop_front();
        `CHK("rdata", e_rd[31:16], bus_rsp.rdata & e_rd[15:0])
      end
    end
    if (iack_ack === 1'b1)
    begin
      if (ia_q.size() == 0) `CHK("stray iack", 1'b0, 1'b1)
      else
      begin
        e_ia = ia_q.pop_front();
        `CHK("vector and arb", e_ia, {iack_vector, iack_arb})
      end
    end
  end

  // watchdog: the sequence needs a few hundred cycles
  initial
  begin
    #(8 * 5000);
    miscompares++;
    wrap_up();
  end

  initial
  begin
    void'($urandom(54));
    repeat (3) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd(mcf_pkg::A_MLAT, mcf_pkg::MLAT_RST, 16'hffff);
    rd(mcf_pkg::A_VEC, {8'h00, mcf_pkg::VEC_RST}, 16'h00ff);
    rd(mcf_pkg::A_CFG, mcf_pkg::CFG_RST, 16'hffff);
    `CHK("dual_action_submodule pin", 1'b0, dual_action_submodule_pin)
    // frozen: halt bit, level 3, arbitration 5
    wr(mcf_pkg::A_CFG, 16'h8305);
    i_mcf_cpu.set_freeze(1'b1);
    repeat (4) @(posedge clock_i);
    wr(mcf_pkg::A_MCNT, 16'h4321);
    rd(mcf_pkg::A_MCNT, 16'h4321, 16'hffff);
    rd(mcf_pkg::A_MLAT, 16'h4321, 16'hffff);
    wr(mcf_pkg::A_MLAT, 16'h5a5a);
    rd(mcf_pkg::A_MCNT, 16'h4321, 16'hffff);
    rd(mcf_pkg::A_MLAT, 16'h5a5a, 16'hffff);
    `CHK("bus one", 16'h4321, tbb.one)
    // free-running count must hold from here while frozen
    fr_v = tbb.two;
    // pin flags keep following while frozen; load pin edges refused
    for (int i = 0; i < 4; i++)
    begin
      p_v = 4'($urandom());
      @(posedge clock_i);
      pins_i <= p_v;
      repeat (4) @(posedge clock_i);
      rd(mcf_pkg::A_MSC, {2'b00, p_v[0], p_v[1], 12'h000}, 16'h3000);
      rd(mcf_pkg::A_FSC, {p_v[2], 15'h0000}, 16'h8000);
      rd(mcf_pkg::A_DCTL, {p_v[3], 15'h0000}, 16'h8000);
    end
    @(posedge clock_i);
    pins_i <= 4'h0;
    repeat (4) @(posedge clock_i);
    `CHK("bus two", fr_v, tbb.two)
    `CHK("bus four", fr_v, tbb.four)
    rd(mcf_pkg::A_FCNT, fr_v, 16'hffff);
    rd(mcf_pkg::A_PCNT, 16'h0000, 16'hffff);
    rd(mcf_pkg::A_MCNT, 16'h4321, 16'hffff);
    // all-ones latch: overflow on every pulse once running
    wr(mcf_pkg::A_MCNT, 16'hffff);
    wr(mcf_pkg::A_MSC, 16'h4000);
    rd(mcf_pkg::A_MSC, 16'h0000, 16'h8000);
    i_mcf_cpu.set_freeze(1'b0);
    repeat (8) @(posedge clock_i);
    rd(mcf_pkg::A_MSC, 16'h8000, 16'h8000);
    rd(mcf_pkg::A_MCNT, 16'hffff, 16'hffff);
    `CHK("irq level", 3'h3, irq_level)
    wr(mcf_pkg::A_VEC, 16'h00a5);
    ia_q.push_back({8'ha5, 4'h5});
    i_mcf_cpu.ack_cycle(3'h3);
    i_mcf_cpu.ack_cycle(3'h2);
    // freeze, clear the flag, then drop the halt bit under freeze
    i_mcf_cpu.set_freeze(1'b1);
    repeat (3) @(posedge clock_i);
    wr(mcf_pkg::A_MSC, 16'h4000);
    repeat (3) @(posedge clock_i);
    `CHK("irq cleared", 3'h0, irq_level)
    wr(mcf_pkg::A_CFG, 16'h0305);
    repeat (8) @(posedge clock_i);
    rd(mcf_pkg::A_MSC, 16'h8000, 16'h8000);
    // random reload value; low byte zero keeps the upper byte exact
    wr(mcf_pkg::A_CFG, 16'h8305);
    lat_v = {8'(($urandom() % 254) + 1), 8'h00};
    wr(mcf_pkg::A_MCNT, 16'hfffd);
    wr(mcf_pkg::A_MLAT, lat_v);
    wr(mcf_pkg::A_MSC, 16'h0000);
    i_mcf_cpu.set_freeze(1'b0);
    repeat (20) @(posedge clock_i);
    i_mcf_cpu.set_freeze(1'b1);
    repeat (3) @(posedge clock_i);
    rd(mcf_pkg::A_MCNT, lat_v, 16'hff00);
    rd(mcf_pkg::A_MSC, 16'h8000, 16'h8000);
    rd(mcf_pkg::A_MLAT, lat_v, 16'hffff);
    // capture refused while frozen, taken once running on the pin clock
    wr(mcf_pkg::A_DCTL, 16'h0001);
    wr(mcf_pkg::A_DDAT, 16'h1234);
    pin_to(4'h8);
    rd(mcf_pkg::A_DDAT, 16'h1234, 16'hffff);
    pin_to(4'h0);
    wr(mcf_pkg::A_MSC, 16'h0001);
    wr(mcf_pkg::A_MCNT, 16'h0100);
    i_mcf_cpu.set_freeze(1'b0);
    pin_to(4'h1);
    pin_to(4'h0);
    pin_to(4'h1);
    pin_to(4'h0);
    rd(mcf_pkg::A_MCNT, 16'h0102, 16'hffff);
    pin_to(4'h8);
    rd(mcf_pkg::A_DDAT, 16'h0102, 16'hffff);
    // output compare toggles once on the first match, not while frozen
    wr(mcf_pkg::A_DCTL, 16'h0004);
    wr(mcf_pkg::A_DDAT, 16'h0103);
    pin_to(4'h9);
    pin_to(4'h8);
    rd(mcf_pkg::A_DCTL, 16'hc004, 16'hc007);
    `CHK("dual_action_submodule pin", 1'b1, dual_action_submodule_pin)
    i_mcf_cpu.set_freeze(1'b1);
    wr(mcf_pkg::A_DDAT, 16'h0000);
    wr(mcf_pkg::A_DDAT, 16'h0103);
    rd(mcf_pkg::A_DCTL, 16'hc004, 16'hc007);
    `CHK("dual_action_submodule pin frozen", 1'b1, dual_action_submodule_pin)
    repeat (4) @(posedge clock_i);
    `CHK("pending answers", 0, rd_q.size() + ia_q.size())
    wrap_up();
  end
endmodule
